// *** rtl/sbr_defines.svh ***
// Offsets, fields, reset values and codes of the SPI bridge executor
// How it works
// - Checked tail forward queues words; link starts only after CRC match.
// - Checked tail forward ignores the transmit start threshold.
// - Unchecked tail forward starts link at threshold or last word.
// - Unchecked CRC miss still executes, sets CRC flag, pulls fault low unless masked.
// - Extra END bytes follow once the data words are on the link.
// - Data words and extra END bytes go out as two link commands.
// - Words returned by the link go into the receive queue.
// - Tail forward and register write answer status then its CRC.
// - Checked data read returns queue words and CRC only on match.
// - Checked reads with a bad command CRC keep the data out high.
// - Unchecked data read returns words and CRC despite a bad CRC.
// - Checked register write holds words in shadow, commits on match.
// - Register commands take the start address from the command word.
// - Unchecked register write stores each word as it arrives.
// - Checked register read with a good CRC returns words and CRC.
// - Unchecked commands always run; checked ones only on CRC match.
// - The status acknowledge is dropped when ack suppress is set.
`ifndef SBR_DEFINES_SVH
`define SBR_DEFINES_SVH

`define SBR_LAST_BIT 4'hF
`define SBR_F_OP 15:12
`define SBR_F_FWDN 11:6
`define SBR_F_ENDS 5:0
`define SBR_F_ADDR 9:6
`define SBR_F_RLEN 3:0
`define SBR_F_DLEN 4:0
`define SBR_F_THR 5:0

`define SBR_OP_FWD 3'b011
`define SBR_OP_DRD 3'b100
`define SBR_OP_RWR 3'b101
`define SBR_OP_RRD 3'b110

`define SBR_R_ID 4'h0
`define SBR_R_SPICTRL 4'h1
`define SBR_R_TXLVL 4'h3
`define SBR_R_DIAGMASK 4'h6
`define SBR_R_STATUS 4'h7
`define SBR_R_IFST 4'h8
`define SBR_R_TXST 4'h9
`define SBR_R_RXST 4'hA
`define SBR_R_LAST 4'hA

`define SBR_B_ACKDIS 0
`define SBR_B_CRCALG 2
`define SBR_B_CRCERR 0
`define SBR_B_MASKCRC 0

`define SBR_RST_SPICTRL 16'h00A0
`define SBR_RST_TXLVL 16'h0004

`define SBR_CRC_POLY 16'h1021
`define SBR_CRC_INIT_A 16'hFFFF
`define SBR_CRC_INIT_B 16'h0000

`endif

// *** rtl/sbr_pkg.sv ***
// Types of the SPI bridge executor
package sbr_pkg;
  typedef enum logic [4:0] {
    ST_CMD = 5'b00001,
    ST_DATA = 5'b00010,
    ST_CRC = 5'b00100,
    ST_RESP = 5'b01000,
    ST_DONE = 5'b10000
  } sbr_state_t;

  typedef enum logic [1:0] {
    RK_NONE = 2'h0,
    RK_ACK = 2'h1,
    RK_REG = 2'h2,
    RK_RXQ = 2'h3
  } sbr_resp_t;
endpackage : sbr_pkg

// *** rtl/sbr_crc16.sv ***
// One-word step of the 16-bit CRC
`include "sbr_defines.svh"

module sbr_crc16 (
  input wire logic [15:0] crc_in,
  input wire logic [15:0] data_in,
  output logic [15:0] crc_out
);
  always_comb
  begin
    crc_out = crc_in;
    for (int i = 15; i >= 0; i--)
    begin
      if (crc_out[15] ^ data_in[i])
        crc_out = {crc_out[14:0], 1'b0} ^ `SBR_CRC_POLY;
      else
        crc_out = {crc_out[14:0], 1'b0};
    end
  end
endmodule : sbr_crc16

// *** rtl/sbr_cmd_exec.sv ***
// SPI command executor: tail forwards, data reads, register access
`include "sbr_defines.svh"

module sbr_cmd_exec #(
  parameter int MAX_WORDS = 32,
  parameter int LVL_W = 7,
  parameter logic [15:0] IDENTIFICATION_WORD = 16'h5A3C  // Arbitrary
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic tx_push,
  output logic [15:0] tx_word,
  output logic tx_flush,
  input wire logic [LVL_W-1:0] tx_level,
  output logic rx_pop,
  input wire logic [15:0] rx_word,
  input wire logic [LVL_W-1:0] rx_level,
  output logic link_release,
  output logic [5:0] link_word_count,
  output logic [5:0] link_extra_ends,
  output logic link_capture_rx,
  output logic link_ends_release,
  input wire logic link_words_sent,
  output logic fault_n
);
  if (MAX_WORDS < 1 || MAX_WORDS > 63 || LVL_W < 1 || LVL_W > 16)
  begin : g_bad_param
    $error("MAX_WORDS or LVL_W out of range");
  end

  function automatic logic writable(input logic [3:0] a);
    writable = a >= `SBR_R_SPICTRL && a <= `SBR_R_DIAGMASK;
  endfunction : writable

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic sclk_s1, sclk_s2, sclk_d, cs_s1, cs_s2, sdi_s1, sdi_s2;
  logic sclk_rise, sclk_fall;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {sclk_s1, sclk_s2, sclk_d} <= 3'h0;
      {cs_s1, cs_s2, sdi_s1, sdi_s2} <= 4'hF;
    end
    else
    begin
      {sclk_s1, sclk_s2, sclk_d} <= {spi_sclk, sclk_s1, sclk_s2};
      {cs_s1, cs_s2} <= {spi_cs_n, cs_s1};
      {sdi_s1, sdi_s2} <= {spi_sdi, sdi_s1};
    end
  end

  assign sclk_rise = sclk_s2 && !sclk_d;
  assign sclk_fall = !sclk_s2 && sclk_d;

  // ----------------------------------------
  // Shared signals
  // ----------------------------------------
  sbr_pkg::sbr_state_t st_reg, st_next;
  sbr_pkg::sbr_resp_t kind_reg, kind_next, kind_sel;
  logic [3:0] op_reg, op_next, bit_cnt_reg, bit_cnt_next;
  logic [3:0] addr_reg, addr_next;
  logic [5:0] idx_reg, idx_next, num_reg, num_next, ends_reg, ends_next;
  logic [5:0] ri, resp_n, fwd_n;
  logic [15:0] in_shift_reg, in_shift_next, out_shift_reg, out_shift_next;
  logic [15:0] crc_in_reg, crc_in_next, crc_out_reg, crc_out_next;
  logic [15:0] crc_i_in, crc_i_out, crc_o_in, crc_o_out, crc_init;
  logic [15:0] word, resp_w, status_w, tx_word_next;
  logic [15:0] shadow_reg [0:15];
  logic [15:0] shadow_next [0:15];
  logic [15:0] cfg_reg [0:15];
  logic [15:0] cfg_next [0:15];
  logic [15:0] view [0:15];
  logic skip_reg, skip_next, sdo_next, released_reg, released_next;
  logic tx_push_next, tx_flush_next, rx_pop_next, rel, step;
  logic link_rel_next, link_ends_rel_next, cap_next, ends_pend_reg;
  logic ends_pend_next;
  logic [5:0] link_cnt_next, link_ends_next;
  logic word_done, match, crc_hit, crc_miss, ack_dis, fault_next;
  logic op_fwd, op_drd, op_rwr, op_rrd, op_chk;
  logic spi_wr_en, commit, crc_set, crc_err_reg, crc_err_next;
  logic [3:0] spi_wr_a;
  logic [15:0] spi_wr_d;
  logic [31:0] prdata_next;
  logic apb_err, apb_wr;

  assign op_fwd = op_reg[3:1] == `SBR_OP_FWD;
  assign op_drd = op_reg[3:1] == `SBR_OP_DRD;
  assign op_rwr = op_reg[3:1] == `SBR_OP_RWR;
  assign op_rrd = op_reg[3:1] == `SBR_OP_RRD;
  assign op_chk = !op_reg[0];
  assign ack_dis = cfg_reg[`SBR_R_SPICTRL][`SBR_B_ACKDIS];
  assign crc_init = cfg_reg[`SBR_R_SPICTRL][`SBR_B_CRCALG] ?
                    `SBR_CRC_INIT_B : `SBR_CRC_INIT_A;
  assign word = {in_shift_reg[14:0], sdi_s2};
  assign word_done = sclk_rise && !cs_s2 && bit_cnt_reg == `SBR_LAST_BIT;
  assign match = word == crc_in_reg;
  assign crc_hit = word_done && st_reg == sbr_pkg::ST_CRC && match;
  assign crc_miss = word_done && st_reg == sbr_pkg::ST_CRC && !match;
  assign status_w = view[`SBR_R_STATUS];
  // Host may ask for more, but the queue side never takes more than this
  assign fwd_n = (word[`SBR_F_FWDN] > 6'(MAX_WORDS)) ?
                 6'(MAX_WORDS) : word[`SBR_F_FWDN];

  // Answer kind decided on the CRC slot, held afterwards
  always_comb
  begin
    kind_sel = kind_reg;
    if (st_reg == sbr_pkg::ST_CRC)
    begin
      if (op_fwd || op_rwr)
        kind_sel = ack_dis ? sbr_pkg::RK_NONE : sbr_pkg::RK_ACK;
      else if (op_chk && !match)
        kind_sel = sbr_pkg::RK_NONE;
      else if (op_drd)
        kind_sel = sbr_pkg::RK_RXQ;
      else if (op_rrd)
        kind_sel = sbr_pkg::RK_REG;
      else
        kind_sel = sbr_pkg::RK_NONE;
    end
  end

  assign ri = (st_reg == sbr_pkg::ST_CRC) ? 6'h00 : idx_reg;
  assign resp_n = (kind_sel == sbr_pkg::RK_ACK) ? 6'h01 : num_reg;
  assign crc_i_in = (st_reg == sbr_pkg::ST_CMD) ? crc_init : crc_in_reg;
  assign crc_o_in = (ri == 6'h00) ? crc_init : crc_out_reg;

  always_comb
  begin
    case (kind_sel)
      sbr_pkg::RK_ACK: resp_w = status_w;
      sbr_pkg::RK_REG: resp_w = view[addr_reg + ri[3:0]];
      sbr_pkg::RK_RXQ: resp_w = rx_word;
      default: resp_w = 16'hFFFF;
    endcase
  end

  sbr_crc16 u_crc_in (
    .crc_in(crc_i_in),
    .data_in(word),
    .crc_out(crc_i_out)
  );

  sbr_crc16 u_crc_out (
    .crc_in(crc_o_in),
    .data_in(resp_w),
    .crc_out(crc_o_out)
  );

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    op_next = op_reg;
    bit_cnt_next = bit_cnt_reg;
    in_shift_next = in_shift_reg;
    idx_next = idx_reg;
    num_next = num_reg;
    addr_next = addr_reg;
    ends_next = ends_reg;
    crc_in_next = crc_in_reg;
    crc_out_next = crc_out_reg;
    out_shift_next = out_shift_reg;
    skip_next = skip_reg;
    sdo_next = spi_sdo;
    kind_next = kind_reg;
    released_next = released_reg;
    shadow_next = shadow_reg;
    tx_word_next = tx_word;
    tx_push_next = 1'b0;
    tx_flush_next = 1'b0;
    rx_pop_next = 1'b0;
    rel = 1'b0;
    step = 1'b0;
    spi_wr_en = 1'b0;
    spi_wr_a = 4'h0;
    spi_wr_d = 16'h0000;
    commit = 1'b0;
    crc_set = 1'b0;
    if (cs_s2)
    begin
      st_next = sbr_pkg::ST_CMD;
      bit_cnt_next = 4'h0;
      skip_next = 1'b0;
      sdo_next = 1'b1;
    end
    else
    begin
      if (sclk_rise)
      begin
        bit_cnt_next = bit_cnt_reg + 4'h1;
        in_shift_next = word;
      end
      // Host supplies the clocks that drain the answer
      if (sclk_fall && st_reg == sbr_pkg::ST_RESP)
      begin
        if (skip_reg)
          skip_next = 1'b0;
        else
        begin
          out_shift_next = {out_shift_reg[14:0], 1'b1};
          sdo_next = out_shift_reg[14];
        end
      end
      if (word_done)
      begin
        case (st_reg)
          sbr_pkg::ST_CMD:
          begin
            op_next = word[`SBR_F_OP];
            idx_next = 6'h00;
            released_next = 1'b0;
            crc_in_next = crc_i_out;
            addr_next = word[`SBR_F_ADDR];
            ends_next = word[`SBR_F_ENDS];
            st_next = sbr_pkg::ST_CRC;
            case (word[15:13])
              `SBR_OP_FWD:
              begin
                num_next = fwd_n;
                if (fwd_n != 6'h00)
                  st_next = sbr_pkg::ST_DATA;
                else
                  rel = word[12];
              end
              `SBR_OP_RWR:
              begin
                num_next = 6'(word[`SBR_F_RLEN]) + 6'h01;
                st_next = sbr_pkg::ST_DATA;
              end
              `SBR_OP_RRD: num_next = 6'(word[`SBR_F_RLEN]) + 6'h01;
              `SBR_OP_DRD: num_next = 6'(word[`SBR_F_DLEN]) + 6'h01;
              default: st_next = sbr_pkg::ST_DONE;
            endcase
          end
          sbr_pkg::ST_DATA:
          begin
            crc_in_next = crc_i_out;
            if (op_fwd)
            begin
              tx_push_next = 1'b1;
              tx_word_next = word;
              // Own count avoids the queue level lagging the push
              if (!op_chk && !released_reg &&
                  (idx_reg + 6'h01 >=
                   cfg_reg[`SBR_R_TXLVL][`SBR_F_THR] ||
                   idx_reg + 6'h01 == num_reg))
                rel = 1'b1;
            end
            else if (op_chk)
              shadow_next[idx_reg[3:0]] = word;
            else
            begin
              spi_wr_en = 1'b1;
              spi_wr_a = addr_reg + idx_reg[3:0];
              spi_wr_d = word;
            end
            idx_next = idx_reg + 6'h01;
            if (idx_reg + 6'h01 == num_reg)
              st_next = sbr_pkg::ST_CRC;
          end
          sbr_pkg::ST_CRC:
          begin
            crc_set = !match;
            kind_next = kind_sel;
            if (op_fwd && op_chk)
            begin
              rel = match;
              tx_flush_next = !match;
            end
            commit = op_rwr && op_chk && match;
            if (kind_sel == sbr_pkg::RK_NONE)
            begin
              st_next = sbr_pkg::ST_DONE;
              sdo_next = 1'b1;
            end
            else
              step = 1'b1;
          end
          sbr_pkg::ST_RESP: step = 1'b1;
          default: ;
        endcase
      end
      if (step)
      begin
        skip_next = 1'b1;
        idx_next = ri + 6'h01;
        st_next = sbr_pkg::ST_RESP;
        if (ri < resp_n)
        begin
          out_shift_next = resp_w;
          sdo_next = resp_w[15];
          crc_out_next = crc_o_out;
          rx_pop_next = kind_sel == sbr_pkg::RK_RXQ;
        end
        else if (ri == resp_n)
        begin
          out_shift_next = crc_out_reg;
          sdo_next = crc_out_reg[15];
        end
        else
        begin
          st_next = sbr_pkg::ST_DONE;
          sdo_next = 1'b1;
        end
      end
    end
    if (rel)
      released_next = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= sbr_pkg::ST_CMD;
      op_reg <= 4'h0;
      bit_cnt_reg <= 4'h0;
      in_shift_reg <= 16'h0000;
      idx_reg <= 6'h00;
      num_reg <= 6'h00;
      addr_reg <= 4'h0;
      ends_reg <= 6'h00;
      crc_in_reg <= 16'h0000;
      crc_out_reg <= 16'h0000;
      out_shift_reg <= 16'hFFFF;
      skip_reg <= 1'b0;
      spi_sdo <= 1'b1;
      kind_reg <= sbr_pkg::RK_NONE;
      released_reg <= 1'b0;
      shadow_reg <= '{default: 16'h0000};
      tx_word <= 16'h0000;
      tx_push <= 1'b0;
      tx_flush <= 1'b0;
      rx_pop <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      op_reg <= op_next;
      bit_cnt_reg <= bit_cnt_next;
      in_shift_reg <= in_shift_next;
      idx_reg <= idx_next;
      num_reg <= num_next;
      addr_reg <= addr_next;
      ends_reg <= ends_next;
      crc_in_reg <= crc_in_next;
      crc_out_reg <= crc_out_next;
      out_shift_reg <= out_shift_next;
      skip_reg <= skip_next;
      spi_sdo <= sdo_next;
      kind_reg <= kind_next;
      released_reg <= released_next;
      shadow_reg <= shadow_next;
      tx_word <= tx_word_next;
      tx_push <= tx_push_next;
      tx_flush <= tx_flush_next;
      rx_pop <= rx_pop_next;
    end
  end

  // ----------------------------------------
  // Link hand-off
  // ----------------------------------------
  always_comb
  begin
    link_rel_next = 1'b0;
    link_ends_rel_next = 1'b0;
    link_cnt_next = link_word_count;
    link_ends_next = link_extra_ends;
    ends_pend_next = ends_pend_reg;
    cap_next = link_capture_rx;
    // Tail ends wait for the word command so the two stay apart
    if (link_words_sent && ends_pend_reg)
    begin
      link_ends_rel_next = link_extra_ends != 6'h00;
      ends_pend_next = 1'b0;
    end
    if (rel)
    begin
      cap_next = 1'b1;
      link_cnt_next = num_next;
      link_ends_next = ends_next;
      if (num_next != 6'h00)
      begin
        link_rel_next = 1'b1;
        ends_pend_next = 1'b1;
      end
      else
        link_ends_rel_next = ends_next != 6'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_release <= 1'b0;
      link_ends_release <= 1'b0;
      link_word_count <= 6'h00;
      link_extra_ends <= 6'h00;
      ends_pend_reg <= 1'b0;
      link_capture_rx <= 1'b0;
    end
    else
    begin
      link_release <= link_rel_next;
      link_ends_release <= link_ends_rel_next;
      link_word_count <= link_cnt_next;
      link_extra_ends <= link_ends_next;
      ends_pend_reg <= ends_pend_next;
      link_capture_rx <= cap_next;
    end
  end

  // ----------------------------------------
  // Register file and APB slave
  // ----------------------------------------
  assign pready = 1'b1;
  assign apb_err = paddr[1:0] != 2'h0 || paddr[7:6] != 2'h0 ||
                   paddr[5:2] > `SBR_R_LAST;
  assign pslverr = psel && penable && apb_err;
  assign apb_wr = psel && penable && pwrite && !apb_err;

  always_comb
  begin
    for (int j = 0; j < 16; j++)
      view[j] = writable(4'(j)) ? cfg_reg[j] : 16'h0000;
    view[`SBR_R_ID] = IDENTIFICATION_WORD;
    view[`SBR_R_STATUS][`SBR_B_CRCERR] = crc_err_reg;
    view[`SBR_R_IFST] = {11'h000, st_reg};
    view[`SBR_R_TXST] = 16'(tx_level);
    view[`SBR_R_RXST] = 16'(rx_level);
  end

  always_comb
  begin
    logic hit;
    logic clr;
    logic [15:0] d;
    logic [3:0] off;
    hit = 1'b0;
    clr = 1'b0;
    d = 16'h0000;
    off = 4'h0;
    cfg_next = cfg_reg;
    for (int j = 0; j < 16; j++)
    begin
      hit = 1'b0;
      d = 16'h0000;
      off = 4'(j) - addr_reg;
      if (apb_wr && paddr[5:2] == 4'(j))
      begin
        hit = 1'b1;
        d = pwdata[15:0];
      end
      if (spi_wr_en && spi_wr_a == 4'(j))
      begin
        hit = 1'b1;
        d = spi_wr_d;
      end
      if (commit && {2'h0, off} < num_reg)
      begin
        hit = 1'b1;
        d = shadow_reg[off];
      end
      if (hit && writable(4'(j)))
        cfg_next[j] = d;
      if (hit && 4'(j) == `SBR_R_STATUS && d[`SBR_B_CRCERR])
        clr = 1'b1;
    end
    // A miss in the clearing cycle still leaves the flag set
    crc_err_next = crc_set || (crc_err_reg && !clr);
    fault_next = !(crc_err_next &&
                   !cfg_next[`SBR_R_DIAGMASK][`SBR_B_MASKCRC]);
    prdata_next = prdata;
    if (psel && !penable)
      prdata_next = {16'h0000, view[paddr[5:2]]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_reg <= '{default: 16'h0000};
      cfg_reg[`SBR_R_SPICTRL] <= `SBR_RST_SPICTRL;
      cfg_reg[`SBR_R_TXLVL] <= `SBR_RST_TXLVL;
      crc_err_reg <= 1'b0;
      fault_n <= 1'b1;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      cfg_reg <= cfg_next;
      crc_err_reg <= crc_err_next;
      fault_n <= fault_next;
      prdata <= prdata_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_gated_release: assert property (
    link_release && op_fwd && op_chk |-> $past(crc_hit))
    else $error("Checked forward released without CRC match");
  chk_early_release: assert property (
    word_done && st_reg == sbr_pkg::ST_DATA && op_fwd && !op_chk &&
    !released_reg && idx_reg + 6'h01 == num_reg |=> link_release)
    else $error("Unchecked forward not released on last word");
  chk_crc_flag: assert property (
    crc_miss |=> crc_err_reg ##1
    (!fault_n || cfg_reg[`SBR_R_DIAGMASK][`SBR_B_MASKCRC] || !crc_err_reg))
    else $error("CRC miss did not raise flag and fault");
  chk_ends_follow: assert property (
    link_words_sent && ends_pend_reg && link_extra_ends != 6'h00 |=>
    link_ends_release && !link_release)
    else $error("Extra END bytes not released after words");
  chk_fail_quiet: assert property (
    crc_miss && op_chk && (op_drd || op_rrd) |=>
    st_reg == sbr_pkg::ST_DONE && spi_sdo)
    else $error("Failed checked read did not hold data out high");
  chk_commit_gate: assert property (
    commit |-> crc_hit && op_rwr && op_chk)
    else $error("Shadow commit without CRC match");
  chk_direct_write: assert property (
    spi_wr_en |-> st_reg == sbr_pkg::ST_DATA && op_rwr && !op_chk)
    else $error("Direct register write outside unchecked write");
  chk_ack_status: assert property (
    word_done && st_reg == sbr_pkg::ST_CRC && (op_fwd || op_rwr) &&
    !ack_dis && !cs_s2 |=> kind_reg == sbr_pkg::RK_ACK &&
    out_shift_reg == $past(status_w) && spi_sdo == out_shift_reg[15])
    else $error("Acknowledge did not start with status");
  chk_pop_data: assert property (
    rx_pop |-> kind_reg == sbr_pkg::RK_RXQ && st_reg == sbr_pkg::ST_RESP)
    else $error("Receive queue popped outside data read");

  cov_release: cover property (link_release);
  cov_ends: cover property (link_ends_release);
  cov_commit: cover property (commit);
  cov_pop: cover property (rx_pop);
endmodule : sbr_cmd_exec

// *** verif/sbr_link_model.sv ***
// Far-side model: link controller and receive queue
module sbr_link_model (
  input wire logic pclk,
  input wire logic tx_push,
  input wire logic tx_flush,
  input wire logic link_release,
  input wire logic link_capture_rx,
  input wire logic [5:0] link_word_count,
  input wire logic rx_pop,
  output logic [6:0] tx_level,
  output logic [15:0] rx_word,
  output logic [6:0] rx_level,
  output logic link_words_sent
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] q[$];
  int busy = 0;
  initial
  begin
    tx_level = 7'h00;
    link_words_sent = 1'h0;
  end
  // Empty queue shows a pattern, never the last word
  assign rx_word = q.size() != 0 ? q[0] : 16'hDEAD;
  assign rx_level = 7'(q.size());
  always @(posedge pclk)
  begin
    link_words_sent <= (busy == 1);
    if (busy != 0)
      busy <= busy - 1;
    if (link_release)
      busy <= 12;
    if (busy == 1 && link_capture_rx)
      repeat (link_word_count) q.push_back(16'($urandom));
    if (rx_pop && q.size() != 0)
      void'(q.pop_front());
    if (tx_push)
      tx_level <= tx_level + 7'h01;
    if (link_release || tx_flush)
      tx_level <= 7'h00;
  end
endmodule : sbr_link_model

// *** verif/spi_bridge_read_and_register_cmds_bench.sv ***
// Self-checking bench of the SPI command executor
module spi_bridge_read_and_register_cmds_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sclk = 0, cs_n = 1, sdi = 1, sdo;
  logic tx_push, tx_flush, rx_pop, rel, cap, erel, sent, fault_n;
  logic [15:0] tx_word, rx_word, e0, e1;
  logic [6:0] tx_level, rx_level;
  logic [5:0] wcnt, ends;
  logic [15:0] r[$], dq[$], txq[$];
  int num_errors = 0, n_compared = 0, rel_n = 0, erel_n = 0, cyc = 0;
  int fl_n = 0;
  sbr_cmd_exec #(.IDENTIFICATION_WORD(16'h3C5A)) i_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
    .spi_sdo(sdo), .tx_push(tx_push), .tx_word(tx_word),
    .tx_flush(tx_flush), .tx_level(tx_level), .rx_pop(rx_pop),
    .rx_word(rx_word), .rx_level(rx_level), .link_release(rel),
    .link_word_count(wcnt), .link_extra_ends(ends),
    .link_capture_rx(cap), .link_ends_release(erel),
    .link_words_sent(sent), .fault_n(fault_n));
  sbr_link_model i_m (.pclk(pclk), .tx_push(tx_push), .tx_flush(tx_flush),
    .link_release(rel), .link_capture_rx(cap), .link_word_count(wcnt),
    .rx_pop(rx_pop), .tx_level(tx_level), .rx_word(rx_word),
    .rx_level(rx_level), .link_words_sent(sent));
  always #20 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    rel_n <= rel_n + int'(rel);
    erel_n <= erel_n + int'(erel);
    fl_n <= fl_n + int'(tx_flush);
    if (tx_push)
      txq.push_back(tx_word);
    if (cyc == 60000)
    begin
      num_errors++;
      test_done();
    end
  end
  function automatic logic [15:0] crc(logic [15:0] c, logic [15:0] d);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'h0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : crc
  task check(input logic [63:0] s, input logic [63:0] x);
    n_compared++;
    if (s !== x)
    begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, s, x);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Ends on the first clock that sees pready high
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task word(input logic [15:0] w, output logic [15:0] o);
    for (int i = 15; i >= 0; i--)
    begin
      sclk <= 0;
      sdi <= w[i];
      repeat (4) @(posedge pclk);
      o[i] = sdo;
      sclk <= 1;
      repeat (4) @(posedge pclk);
    end
  endtask : word
  // Command, nd random words, CRC (spoiled if bad), then na answer words
  task cmd(input logic [15:0] c, input int nd, input logic bad, input int na);
    logic [15:0] k, d, o;
    dq = {};
    r = {};
    @(posedge pclk);
    cs_n <= 0;
    repeat (4) @(posedge pclk);
    word(c, o);
    k = crc(16'hFFFF, c);
    for (int i = 0; i < nd; i++)
    begin
      d = 16'($urandom);
      dq.push_back(d);
      word(d, o);
      k = crc(k, d);
    end
    word(k ^ {15'h0000, bad}, o);
    for (int i = 0; i < na; i++)
    begin
      word(16'hFFFF, o);
      r.push_back(o);
    end
    @(posedge pclk);
    sclk <= 0;
    sdi <= 1;
    repeat (4) @(posedge pclk);
    cs_n <= 1;
    repeat (30) @(posedge pclk);
  endtask : cmd
  task test_done();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  initial
  begin
    void'($urandom(38300));
    repeat (3) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    apb(0, 8'h00, 0);
    check(rd, 32'h3C5A);
    apb(0, 8'h04, 0);
    check(rd, 32'h00A0);
    apb(0, 8'h2C, 0);
    check(err, 1'h1);
    $display("registers done");
    cmd(16'h6081, 2, 0, 2);
    check(txq.size(), 2);
    check({txq[0], txq[1]}, {dq[0], dq[1]});
    check({rel_n, wcnt, ends}, {32'd1, 6'd2, 6'd1});
    check({r[0], r[1]}, {16'h0000, crc(16'hFFFF, 16'h0000)});
    check(erel_n, 1);
    apb(1, 8'h0C, 32'h0001);
    cmd(16'h6081, 2, 1, 2);
    check({rel_n, fault_n}, {32'd1, 1'h0});
    check(fl_n, 1);
    apb(0, 8'h1C, 0);
    check(rd[0], 1'h1);
    apb(1, 8'h1C, 32'h0001);
    cmd(16'h7081, 2, 1, 2);
    check({rel_n, fault_n}, {32'd2, 1'h0});
    apb(1, 8'h1C, 32'h0001);
    $display("forward done");
    e0 = i_m.q[0];
    e1 = i_m.q[1];
    cmd(16'h8001, 0, 0, 3);
    check({r[0], r[1], r[2]}, {e0, e1, crc(crc(16'hFFFF, e0), e1)});
    cmd(16'h8001, 0, 1, 2);
    check({r[0], r[1]}, 32'hFFFFFFFF);
    e0 = i_m.q[0];
    cmd(16'h9000, 0, 1, 2);
    check({r[0], r[1]}, {e0, crc(16'hFFFF, e0)});
    $display("data read done");
    cmd(16'hB0C0, 1, 1, 2);
    apb(0, 8'h0C, 0);
    check(rd[5:0], dq[0][5:0]);
    e0 = dq[0];
    cmd(16'hA0C0, 1, 1, 2);
    apb(0, 8'h0C, 0);
    check(rd[5:0], e0[5:0]);
    cmd(16'hA0C0, 1, 0, 2);
    apb(0, 8'h0C, 0);
    check(rd[5:0], dq[0][5:0]);
    cmd(16'hC001, 0, 0, 3);
    check({r[0], r[1], r[2]}, {16'h3C5A, 16'h00A0,
      crc(crc(16'hFFFF, 16'h3C5A), 16'h00A0)});
    cmd(16'hC000, 0, 1, 2);
    check({r[0], r[1]}, 32'hFFFFFFFF);
    // Ack suppressed, CRC fault masked, flag cleared first
    apb(1, 8'h04, 32'h00A1);
    apb(1, 8'h18, 32'h0001);
    apb(1, 8'h1C, 32'h0001);
    cmd(16'hB0C0, 1, 0, 2);
    check({r[0], r[1]}, 32'hFFFFFFFF);
    cmd(16'hD000, 0, 1, 2);
    check({r[0], r[1], fault_n},
      {16'h3C5A, crc(16'hFFFF, 16'h3C5A), 1'h1});
    apb(0, 8'h1C, 0);
    check(rd[0], 1'h1);
    $display("register commands done");
    test_done();
  end
endmodule : spi_bridge_read_and_register_cmds_bench
